/* File: swdt_pkg.sv */
`default_nettype none
package swdt_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] SWDT_CTRL_OFF    = 12'h000;
  localparam logic [11:0] SWDT_STATUS_OFF  = 12'h004;

  // ==========================================================================
  // control codes
  localparam logic [7:0]  SWDT_CODE_RESTART = 8'hA5;
  localparam logic [7:0]  SWDT_CODE_DIS1    = 8'hDE;
  localparam logic [7:0]  SWDT_CODE_DIS2    = 8'hAD;
  localparam logic [7:0]  SWDT_CODE_LOCK    = 8'hFF;

  // ==========================================================================
  // fields and sizes
  localparam int          SWDT_CNT_W        = 21;
  localparam int          SWDT_IVL_W        = 3;
  localparam int          SWDT_MSB_BIT      = 7;
  localparam logic [2:0]  SWDT_IVL_RESET    = 3'h7;
  localparam int          SWDT_IVL_BASE     = 3;
  // pair window in clock cycles
  localparam int          SWDT_DIS_WIN_CYC  = 4;
  localparam logic [2:0]  SWDT_DIS_WIN      = 3'(SWDT_DIS_WIN_CYC);
  localparam int          SWDT_RST_HOLD_CYC = 2;
  localparam logic [1:0]  SWDT_RST_HOLD     = 2'(SWDT_RST_HOLD_CYC);

  // status bit positions
  localparam int          SWDT_ST_EN_BIT    = 0;
  localparam int          SWDT_ST_LOCK_BIT  = 1;
  localparam int          SWDT_ST_ARM_BIT   = 2;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } swdt_req_s;

endpackage : swdt_pkg
`default_nettype wire

/* File: swdt_top.sv */
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Function
// - counter overflow drives the whole chip into reset
// - after any system reset: enabled, counting, longest interval
// - once locked, every disable attempt refused until next reset
// - watchdog reset never drives the external reset pin
// - 21-bit counter on system clock, measures time since restart
// - writing A5 enables the watchdog and clears the counter
// - DE then AD, in that order, disables the watchdog
// - AD later than 4 cycles after DE is ignored
// - writing FF sets the lock against later disables
// - writing FF neither enables nor clears the counter
// - timeout is 4 to the power (3 + interval field) clocks
// - control register reads return the interval field; it resets to all ones
module swdt_top (
  input  wire logic        clock,        // system clock, 40 MHz
  input  wire logic        rst,          // async system reset, active high
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [11:0] paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error, unmapped address
  output logic             wdt_rst_req,  // internal chip reset request
  output logic             rst_pin_oe    // external reset pin enable, never set
);
  import swdt_pkg::*;

  // ==========================================================================
  // apb decode
  swdt_req_s req;
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  wire setup_ok  = psel & ~penable;
  wire hit_ctrl  = (req.addr == SWDT_CTRL_OFF);
  wire hit_stat  = (req.addr == SWDT_STATUS_OFF);
  wire hit_any   = hit_ctrl | hit_stat;
  // answer lands one cycle after setup: access phase sees pready high
  wire acc_go    = setup_ok;
  wire ctrl_wr   = psel & penable & pready & req.write & hit_ctrl;
  wire [7:0] wb  = req.wdata[7:0];

  wire is_restart = ctrl_wr & (wb == SWDT_CODE_RESTART);
  wire is_dis1    = ctrl_wr & (wb == SWDT_CODE_DIS1);
  wire is_dis2    = ctrl_wr & (wb == SWDT_CODE_DIS2);
  wire is_lock    = ctrl_wr & (wb == SWDT_CODE_LOCK);
  // interval is taken from writes with bit 7 low that are not codes
  wire is_ivl     = ctrl_wr & ~wb[SWDT_MSB_BIT] & ~is_dis2;

  // ==========================================================================
  // state
  logic                  en_q, en_d;
  logic                  lock_q, lock_d;
  logic [SWDT_IVL_W-1:0] ivl_q, ivl_d;
  logic [SWDT_CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0]            win_q, win_d;
  logic [1:0]            hold_q, hold_d;
  logic                  overflow;

  // timeout limit: 4^(3+ivl) = 2^(6+2*ivl) cycles
  function automatic logic [SWDT_CNT_W:0] limit_of(input logic [SWDT_IVL_W-1:0] iv);
    limit_of = (SWDT_CNT_W+1)'(1) << (2 * (SWDT_IVL_BASE + int'(iv)));
  endfunction

  wire [SWDT_CNT_W:0] lim = limit_of(ivl_q);
  // counting from zero, compare with lim - 1 so overflow comes lim cycles after a clear
  assign overflow = en_q & ({1'b0, cnt_q} == (lim - (SWDT_CNT_W+1)'(1)));

  wire pair_ok = is_dis2 & (win_q != 3'h0) & ~lock_q;

  assign en_d   = is_restart ? 1'b1 : (pair_ok ? 1'b0 : en_q);
  assign lock_d = lock_q | is_lock;
  assign ivl_d  = is_ivl ? wb[SWDT_IVL_W-1:0] : ivl_q;
  // counter clears on restart and on overflow, stays at zero while disabled
  assign cnt_d  = (is_restart | ~en_q | overflow) ? '0 : cnt_q + 1'b1;
  // window opens on DE; any other control write closes it
  assign win_d  = is_dis1 ? SWDT_DIS_WIN :
                  (ctrl_wr ? 3'h0 : (win_q != 3'h0 ? win_q - 3'h1 : 3'h0));
  assign hold_d = overflow ? SWDT_RST_HOLD : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);

  // ==========================================================================
  // registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_q   <= 1'b1;
      lock_q <= 1'b0;
      ivl_q  <= SWDT_IVL_RESET;
      cnt_q  <= '0;
      win_q  <= 3'h0;
      hold_q <= 2'h0;
    end else begin
      en_q   <= en_d;
      lock_q <= lock_d;
      ivl_q  <= ivl_d;
      cnt_q  <= cnt_d;
      win_q  <= win_d;
      hold_q <= hold_d;
    end
  end

  // ==========================================================================
  // outputs
  wire [31:0] rd_ctrl = {29'h0, ivl_q};
  wire [31:0] rd_stat = {29'h0, win_q != 3'h0, lock_q, en_q};
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl : (hit_stat ? rd_stat : 32'h0);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata      <= 32'h0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      wdt_rst_req <= 1'b0;
      rst_pin_oe  <= 1'b0;
    end else begin
      pready      <= acc_go;
      pslverr     <= acc_go & ~hit_any;
      prdata      <= (acc_go & ~req.write) ? rd_mux : 32'h0;
      wdt_rst_req <= overflow | (hold_d != 2'h0);
      rst_pin_oe  <= 1'b0;
    end
  end

endmodule // swdt_top

`default_nettype wire

/* File: swdt_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module swdt_top_checker (
  input wire logic        clock, // clk
  input wire logic        rst, // reset
  input wire logic        psel, // sel
  input wire logic        penable, // en
  input wire logic        pwrite, // dir
  input wire logic [11:0] paddr, // addr
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic        pready, // ready
  input wire logic        pslverr, // err
  input wire logic        wdt_rst_req, // chip reset
  input wire logic        rst_pin_oe // pin oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  pin_idle_a: assert property (!rst_pin_oe) else $error("pin");
  // request stands on the overflow edge plus one hold cycle
  req_len_a: assert property ($rose(wdt_rst_req) |-> wdt_rst_req[*2]) else $error("r");
  rd_fld_a: assert property (pready && !paddr |-> !prdata[31:3]) else $error("f");
  rdy_next_a: assert property (psel && !penable |=> pready) else $error("n");
  rdy_idle_a: assert property (!psel |=> !pready) else $error("i");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("p");
  rd_idle_a: assert property (!pready |-> !prdata) else $error("d");
  err_hole_a: assert property (pready && paddr[11:3] != 9'h0 |-> pslverr) else $error("e");
  cover property ($rose(wdt_rst_req));
  cover property (pready && pslverr);
  cover property (pready && pwrite);
endmodule // swdt_top_checker
bind swdt_top swdt_top_checker u_chk (
  .clock       (clock),
  .rst         (rst),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .paddr       (paddr),
  .pwdata      (pwdata),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .wdt_rst_req (wdt_rst_req),
  .rst_pin_oe  (rst_pin_oe)
);
`default_nettype wire

/* File: swdt_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module swdt_top_bench;
  import swdt_pkg::*;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, wdt_rst_req, rst_pin_oe;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  int          n_errors = 0, n_compared = 0, k;
  swdt_top u_dut (
    .clock       (clock),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .wdt_rst_req (wdt_rst_req),
    .rst_pin_oe  (rst_pin_oe)
  );
  initial forever #12.5 clock = ~clock;
  task summarize;
    $display("errors %0d of %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) $display("[ERR] %s exp %h got %h", nm, e, s);
    if (s !== e) n_errors++;
  endtask
  // starts right after an edge and leaves the bus selected, so a next transfer
  // may follow at once; idle releases the bus
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, e);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    if (!w) chk("rdata", prdata, e);
    chk("slverr", 32'(pslverr), 32'(a != SWDT_CTRL_OFF && a != SWDT_STATUS_OFF));
  endtask
  task idle(input int g);
    {psel, penable} <= 2'h0;
    repeat (g) @(posedge clock);
  endtask
  task wr3(input logic [7:0] a, b, c, input int g, input logic [31:0] e);
    xfer(1'b1, SWDT_CTRL_OFF, 32'(a), 32'h0);
    if (g > 0) idle(g);
    xfer(1'b1, SWDT_CTRL_OFF, 32'(b), 32'h0);
    xfer(1'b1, SWDT_CTRL_OFF, 32'(c), 32'h0);
    xfer(1'b0, SWDT_STATUS_OFF, 32'h0, e);
    idle(1);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    xfer(1'b0, SWDT_CTRL_OFF, 32'h0, 32'h7);
    xfer(1'b1, 12'h008, 32'h0, 32'h0);
    wr3(8'h07, 8'hDE, 8'hAD, 0, 32'h0);
    wr3(8'hFF, 8'hDE, 8'hAD, 0, 32'h2);
    wr3(8'hDE, 8'h00, 8'hA5, 0, 32'h3);
    wr3(8'h00, 8'hDE, 8'hAD, 0, 32'h3);
    // restarts well inside the 64-cycle interval keep the request low
    repeat (3) begin
      xfer(1'b1, SWDT_CTRL_OFF, 32'hA5, 32'h0);
      idle(50);
      chk("early_req", 32'(wdt_rst_req), 32'h0);
    end
    xfer(1'b1, SWDT_CTRL_OFF, 32'hA5, 32'h0);
    idle(0);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wdt_rst_req !== 1'b1 && k < 200);
    // interval field 0: 4^3 cycles, then one edge for the registered request
    chk("timeout", 32'(k), 32'((1 << (2 * SWDT_IVL_BASE)) + 1));
    chk("pin_oe", 32'(rst_pin_oe), 32'h0);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    xfer(1'b0, SWDT_CTRL_OFF, 32'h0, 32'h7);
    wr3(8'hDE, 8'hAD, 8'h07, 3, 32'h1);
    wr3(8'hDE, 8'h07, 8'hAD, 0, 32'h1);
    wr3(8'hDE, 8'hAD, 8'h07, 2, 32'h0);
    summarize;
  end
  initial #25000 begin
    n_errors++;
    summarize;
  end
endmodule // swdt_top_bench
`default_nettype wire
